// file: src/urx_params.svh
// constants of the serial receive path: offsets, fields, resets, timing
`ifndef URX_PARAMS_SVH
`define URX_PARAMS_SVH

// register byte offsets
`define URX_OFF_CTRL1 8'h00
`define URX_OFF_CTRL2 8'h04
`define URX_OFF_CTRL3 8'h08
`define URX_OFF_DIV 8'h0c
`define URX_OFF_REQ 8'h18
`define URX_OFF_STAT 8'h1c
`define URX_OFF_ICLR 8'h20
`define URX_OFF_HOLD 8'h24

// writable masks and reset values
`define URX_CTRL1_MASK 32'h0000_9735
`define URX_CTRL2_MASK 32'h0000_7000
`define URX_CTRL3_MASK 32'h0000_1861
`define URX_CTRL_RST 32'h0000_0000
`define URX_DIV_RST 16'h0010

// first control register fields
`define URX_B_UNIT_ON 0
`define URX_B_RX_ON 2
`define URX_B_QUIET_IE 4
`define URX_B_FULL_IE 5
`define URX_B_PAR_IE 8
`define URX_B_PAR_ODD 9
`define URX_B_PAR_EN 10
`define URX_B_WORD_LEN 12
`define URX_B_HALF_OVS 15

// second and third control register fields
`define URX_B_STOP_LO 12
`define URX_B_LIN_EN 14
`define URX_B_ERR_IE 0
`define URX_B_SCARD_EN 5
`define URX_B_DMA_EN 6
`define URX_B_SINGLE 11
`define URX_B_OVR_OFF 12

// request, status and clear fields
`define URX_B_FLUSH 3
`define URX_B_PAR_F 0
`define URX_B_STOP_F 1
`define URX_B_GLITCH_F 2
`define URX_B_OVR_F 3
`define URX_B_QUIET_F 4
`define URX_B_FULL_F 5
`define URX_B_ACK_F 22

// sample positions within a bit, counted from 1
`define URX_N8 5'h08
`define URX_N16 5'h10
`define URX_CEN8 5'h05
`define URX_CEN16 5'h09
`define URX_GA0 5'h03
`define URX_GA1 5'h05
`define URX_GA2 5'h07

// idle frame length in sample ticks (10 or 11 bits)
`define URX_IDLE8_W8 8'h50
`define URX_IDLE8_W9 8'h58
`define URX_IDLE16_W8 8'ha0
`define URX_IDLE16_W9 8'hb0

`endif

// file: src/urx_pkg.sv
// types of the serial receive path
package urx_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } urx_bus_req_t;

  typedef enum logic [1:0] {
    URX_IDLE = 2'b00,
    URX_START = 2'b01,
    URX_DATA = 2'b10,
    URX_STOP = 2'b11
  } urx_state_t;

  typedef enum logic [1:0] {
    URX_STOP_1 = 2'b00,
    URX_STOP_HALF = 2'b01,
    URX_STOP_2 = 2'b10,
    URX_STOP_1P5 = 2'b11
  } urx_stop_t;

  typedef struct packed {
    logic [8:0] data;
    logic glitch;
    logic stop_fault;
    logic par_fault;
  } urx_char_t;

endpackage : urx_pkg

// file: src/urx_rx.sv
// serial receive path: start detect, sampling, holding register, flags
//
// Behaviour
// - 8x: start confirmed when ticks 4, 5, 6 after the edge are low
// - 16x: start needs two of ticks 3,5,7 and two of ticks 8,9,10 low
// - two of three low in a start group: accept, raise glitch_flag unless single sample
// - start check failing either test: back to idle, no flag
// - characters of 8 or 9 data bits by word_len_sel
// - software sets rx_on after setup; rx_ack_flag shows readiness
// - completed character goes to rx_hold_reg; read clears rx_full_flag
// - rx_flush_req write clears rx_full_flag without a read
// - with rx_dma_en a DMA request per character; DMA read clears full
// - all-zero break frame is reported as a stop fault unless stop_len_sel selects half a stop bit
// - idle frame sets the quiet flag; interrupt when quiet_irq_en
// - character while full or DMA pending sets overrun_flag; interrupts
// - during overrun rx_hold_reg kept; new characters are lost
// - overrun_clr clears; overrun_detect_off keeps flag at 0
// - half_oversample_sel bit 15: 1 gives 8x, 0 gives 16x
// - smartcard or LIN forces 16x oversampling
// - majority of three centre samples or one centre sample
// - glitch_flag rises with rx_full_flag; data still loaded
// - glitch_clr clears glitch_flag
// - missing stop bit: stop_fault_flag, data loaded, full set
// - stop_fault_clr clears stop_fault_flag
// - stop_len_sel chooses where and whether the stop bit is checked
// - bit rate is clock over divider at 16x, twice that at 8x
// - wrong parity sets parity_fault_flag, cleared by its clear bit
`timescale 1ns/1ns
`default_nettype none
`include "urx_params.svh"

module urx_rx (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // register port
  input wire urx_pkg::urx_bus_req_t i_bus,
  output var logic [31:0] o_rdata,
  // serial line
  input wire logic i_rx,
  // dma and interrupt
  input wire logic i_dma_ack,
  output var logic o_rx_dma_req,
  output var logic o_irq
);

  function automatic logic [1:0] zeros3(input logic [2:0] s);
    zeros3 = {1'b0, ~s[0]} + {1'b0, ~s[1]} + {1'b0, ~s[2]};
  endfunction : zeros3

  function automatic logic vote3(input logic [2:0] s);
    vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : vote3

  logic [31:0] ctrl1_reg;
  logic [31:0] ctrl2_reg;
  logic [31:0] ctrl3_reg;
  logic [15:0] div_reg;
  logic [8:0] hold_reg;
  logic full_reg;
  logic glitch_reg;
  logic stop_f_reg;
  logic par_f_reg;
  logic ovr_reg;
  logic quiet_reg;
  logic ack_reg;
  logic [11:0] tick_cnt_reg;
  logic tick;
  urx_pkg::urx_state_t state_reg;
  logic [4:0] pos_reg;
  logic [3:0] idx_reg;
  logic [1:0] win_reg;
  logic [2:0] ga_reg;
  logic line_prev_reg;
  logic [8:0] sh_reg;
  logic noise_reg;
  logic done_reg;
  urx_pkg::urx_char_t done_char_reg;
  logic armed_reg;
  logic [7:0] hi_cnt_reg;
  logic quiet_ev;

  // register strobes
  logic wr_c1;
  logic wr_c2;
  logic wr_c3;
  logic wr_div;
  logic wr_req;
  logic wr_clr;
  logic rd_hold;
  assign wr_c1 = i_bus.wr && (i_bus.addr == `URX_OFF_CTRL1);
  assign wr_c2 = i_bus.wr && (i_bus.addr == `URX_OFF_CTRL2);
  assign wr_c3 = i_bus.wr && (i_bus.addr == `URX_OFF_CTRL3);
  assign wr_div = i_bus.wr && (i_bus.addr == `URX_OFF_DIV);
  assign wr_req = i_bus.wr && (i_bus.addr == `URX_OFF_REQ);
  assign wr_clr = i_bus.wr && (i_bus.addr == `URX_OFF_ICLR);
  assign rd_hold = i_bus.rd && (i_bus.addr == `URX_OFF_HOLD);

  // configuration fields
  logic unit_on;
  logic rx_on;
  logic word9;
  logic force16;
  logic half_ovs;
  logic single;
  logic ovr_off;
  logic dma_en;
  logic err_ie;
  logic full_ie;
  urx_pkg::urx_stop_t stop_sel;
  assign unit_on = ctrl1_reg[`URX_B_UNIT_ON];
  assign rx_on = ctrl1_reg[`URX_B_RX_ON];
  assign word9 = ctrl1_reg[`URX_B_WORD_LEN];
  assign force16 = ctrl2_reg[`URX_B_LIN_EN] | ctrl3_reg[`URX_B_SCARD_EN];
  assign half_ovs = ctrl1_reg[`URX_B_HALF_OVS] & ~force16;
  assign single = ctrl3_reg[`URX_B_SINGLE];
  assign ovr_off = ctrl3_reg[`URX_B_OVR_OFF];
  assign dma_en = ctrl3_reg[`URX_B_DMA_EN];
  assign err_ie = ctrl3_reg[`URX_B_ERR_IE];
  assign full_ie = ctrl1_reg[`URX_B_FULL_IE];
  assign stop_sel = urx_pkg::urx_stop_t'(ctrl2_reg[`URX_B_STOP_LO +: 2]);

  // control registers
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl1_reg <= `URX_CTRL_RST;
      ctrl2_reg <= `URX_CTRL_RST;
      ctrl3_reg <= `URX_CTRL_RST;
      div_reg <= `URX_DIV_RST;
    end else begin
      if (wr_c1) begin
        ctrl1_reg <= i_bus.wdata & `URX_CTRL1_MASK;
      end
      if (wr_c2) begin
        ctrl2_reg <= i_bus.wdata & `URX_CTRL2_MASK;
      end
      if (wr_c3) begin
        ctrl3_reg <= i_bus.wdata & `URX_CTRL3_MASK;
      end
      if (wr_div) begin
        div_reg <= i_bus.wdata[15:0];
      end
    end
  end

  // receiver ready once enabled
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= unit_on & rx_on;
    end
  end

  // sample tick: divider over 16 clocks per tick in both modes
  logic [11:0] tick_load;
  assign tick_load = (div_reg[15:4] == 12'h000) ? 12'h000 : div_reg[15:4] - 12'h001;
  assign tick = ack_reg && (tick_cnt_reg == 12'h000);
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tick_cnt_reg <= 12'h000;
    end else if (!ack_reg || tick_cnt_reg == 12'h000) begin
      tick_cnt_reg <= tick_load;
    end else begin
      tick_cnt_reg <= tick_cnt_reg - 12'h001;
    end
  end

  // sampling geometry
  logic [4:0] nbit;
  logic [4:0] cen;
  logic [4:0] eval_pos;
  logic in_win;
  logic at_eval;
  logic in_ga;
  logic [2:0] wnow;
  logic bitv;
  logic bit_noisy;
  logic [1:0] zb;
  logic [1:0] za;
  logic start_ok;
  logic start_noisy;
  logic stop_late;
  assign nbit = half_ovs ? `URX_N8 : `URX_N16;
  assign cen = half_ovs ? `URX_CEN8 : `URX_CEN16;
  assign stop_late = (state_reg == urx_pkg::URX_STOP) && (stop_sel == urx_pkg::URX_STOP_1P5);
  assign eval_pos = stop_late ? nbit : cen + 5'h01;
  assign in_win = (pos_reg >= eval_pos - 5'h02) && (pos_reg <= eval_pos);
  assign at_eval = tick && (pos_reg == eval_pos);
  assign in_ga = !half_ovs && ((pos_reg == `URX_GA0) || (pos_reg == `URX_GA1)
                               || (pos_reg == `URX_GA2));
  assign wnow = {win_reg, i_rx};
  assign bitv = single ? wnow[1] : vote3(wnow);
  assign bit_noisy = !single && (wnow != 3'b000) && (wnow != 3'b111);
  assign zb = zeros3(wnow);
  assign za = zeros3(ga_reg);
  assign start_ok = (zb >= 2'd2) && (half_ovs || za >= 2'd2);
  assign start_noisy = !single && ((zb == 2'd2) || (!half_ovs && za == 2'd2));

  // character assembled this tick
  logic [8:0] word;
  logic par_bad;
  assign word = {word9 & sh_reg[8], sh_reg[7:0]};
  assign par_bad = ctrl1_reg[`URX_B_PAR_EN] & (^word ^ ctrl1_reg[`URX_B_PAR_ODD]);

  // receive state machine
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= urx_pkg::URX_IDLE;
      pos_reg <= 5'h01;
      idx_reg <= 4'h0;
      win_reg <= 2'b11;
      ga_reg <= 3'b111;
      line_prev_reg <= 1'b1;
      sh_reg <= 9'h000;
      noise_reg <= 1'b0;
      done_reg <= 1'b0;
      done_char_reg <= '0;
    end else begin
      done_reg <= 1'b0;
      if (!ack_reg) begin
        state_reg <= urx_pkg::URX_IDLE;
        line_prev_reg <= 1'b1;
      end else if (tick) begin
        line_prev_reg <= i_rx;
        pos_reg <= (pos_reg == nbit) ? 5'h01 : pos_reg + 5'h01;
        if (in_win) begin
          win_reg <= wnow[1:0];
        end
        if (in_ga) begin
          ga_reg <= {ga_reg[1:0], i_rx};
        end
        unique case (state_reg)
          urx_pkg::URX_IDLE: begin
            if (line_prev_reg && !i_rx) begin
              state_reg <= urx_pkg::URX_START;
              pos_reg <= 5'h02;
              sh_reg <= 9'h000;
              noise_reg <= 1'b0;
            end
          end
          urx_pkg::URX_START: begin
            if (at_eval) begin
              if (!start_ok) begin
                state_reg <= urx_pkg::URX_IDLE;
              end else begin
                noise_reg <= start_noisy;
              end
            end else if (pos_reg == nbit) begin
              state_reg <= urx_pkg::URX_DATA;
              idx_reg <= 4'h0;
            end
          end
          urx_pkg::URX_DATA: begin
            if (at_eval) begin
              sh_reg[idx_reg] <= bitv;
              noise_reg <= noise_reg | bit_noisy;
            end
            if (pos_reg == nbit) begin
              if (idx_reg == (word9 ? 4'h8 : 4'h7)) begin
                state_reg <= urx_pkg::URX_STOP;
              end else begin
                idx_reg <= idx_reg + 4'h1;
              end
            end
          end
          urx_pkg::URX_STOP: begin
            if (stop_sel == urx_pkg::URX_STOP_HALF) begin
              if (pos_reg == {1'b0, nbit[4:1]}) begin
                state_reg <= urx_pkg::URX_IDLE;
                done_reg <= 1'b1;
                done_char_reg <= '{word, noise_reg, 1'b0, par_bad};
              end
            end else if (at_eval) begin
              state_reg <= urx_pkg::URX_IDLE;
              done_reg <= 1'b1;
              done_char_reg <= '{word, noise_reg | bit_noisy, !bitv, par_bad};
            end
          end
        endcase
      end
    end
  end

  // idle frame watch: line high for one full frame after activity
  logic [7:0] idle_len;
  assign idle_len = half_ovs ? (word9 ? `URX_IDLE8_W9 : `URX_IDLE8_W8)
                             : (word9 ? `URX_IDLE16_W9 : `URX_IDLE16_W8);
  assign quiet_ev = armed_reg && tick && i_rx && (hi_cnt_reg == idle_len - 8'h01);
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      armed_reg <= 1'b0;
      hi_cnt_reg <= 8'h00;
    end else begin
      if (!ack_reg) begin
        armed_reg <= 1'b0;
      end else if (done_reg || state_reg != urx_pkg::URX_IDLE) begin
        armed_reg <= 1'b1;
      end else if (quiet_ev) begin
        armed_reg <= 1'b0;
      end
      if (!ack_reg || state_reg != urx_pkg::URX_IDLE || quiet_ev) begin
        hi_cnt_reg <= 8'h00;
      end else if (tick) begin
        hi_cnt_reg <= i_rx ? hi_cnt_reg + 8'h01 : 8'h00;
      end
    end
  end

  // overrun decision and load into the holding register
  logic ovr_hit;
  logic load;
  logic dma_rd;
  logic flush;
  assign dma_rd = i_dma_ack & o_rx_dma_req;
  assign flush = wr_req && i_bus.wdata[`URX_B_FLUSH];
  assign ovr_hit = done_reg && !ovr_off && (full_reg || o_rx_dma_req);
  assign load = done_reg && (ovr_off || (!ovr_hit && !ovr_reg));

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hold_reg <= 9'h000;
    end else if (load) begin
      hold_reg <= done_char_reg.data;
    end
  end

  // full flag, set wins over clear
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      full_reg <= 1'b0;
    end else if (load) begin
      full_reg <= 1'b1;
    end else if (rd_hold || dma_rd || flush) begin
      full_reg <= 1'b0;
    end
  end

  // dma request per character
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rx_dma_req <= 1'b0;
    end else if (load && dma_en) begin
      o_rx_dma_req <= 1'b1;
    end else if (i_dma_ack || !dma_en) begin
      o_rx_dma_req <= 1'b0;
    end
  end

  // error flags latched with the full flag
  logic [4:0] clr;
  assign clr = wr_clr ? i_bus.wdata[4:0] : 5'h00;
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      glitch_reg <= 1'b0;
      stop_f_reg <= 1'b0;
      par_f_reg <= 1'b0;
    end else begin
      if (load && done_char_reg.glitch) begin
        glitch_reg <= 1'b1;
      end else if (clr[`URX_B_GLITCH_F]) begin
        glitch_reg <= 1'b0;
      end
      if (load && done_char_reg.stop_fault) begin
        stop_f_reg <= 1'b1;
      end else if (clr[`URX_B_STOP_F]) begin
        stop_f_reg <= 1'b0;
      end
      if (load && done_char_reg.par_fault) begin
        par_f_reg <= 1'b1;
      end else if (clr[`URX_B_PAR_F]) begin
        par_f_reg <= 1'b0;
      end
    end
  end

  // overrun and quiet flags
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ovr_reg <= 1'b0;
      quiet_reg <= 1'b0;
    end else begin
      if (ovr_off) begin
        ovr_reg <= 1'b0;
      end else if (ovr_hit) begin
        ovr_reg <= 1'b1;
      end else if (clr[`URX_B_OVR_F]) begin
        ovr_reg <= 1'b0;
      end
      if (quiet_ev) begin
        quiet_reg <= 1'b1;
      end else if (clr[`URX_B_QUIET_F]) begin
        quiet_reg <= 1'b0;
      end
    end
  end

  // interrupt request
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= (quiet_reg & ctrl1_reg[`URX_B_QUIET_IE])
             | (full_reg & full_ie)
             | (ovr_reg & (full_ie | err_ie))
             | ((glitch_reg | stop_f_reg) & err_ie)
             | (par_f_reg & ctrl1_reg[`URX_B_PAR_IE]);
    end
  end

  // status word
  logic [31:0] stat;
  always_comb begin
    stat = 32'h0000_0000;
    stat[`URX_B_PAR_F] = par_f_reg;
    stat[`URX_B_STOP_F] = stop_f_reg;
    stat[`URX_B_GLITCH_F] = glitch_reg;
    stat[`URX_B_OVR_F] = ovr_reg;
    stat[`URX_B_QUIET_F] = quiet_reg;
    stat[`URX_B_FULL_F] = full_reg;
    stat[`URX_B_ACK_F] = ack_reg;
  end

  // read data, valid only in the cycle after the strobe
  logic [31:0] c1_view;
  assign c1_view = {ctrl1_reg[31:16], half_ovs, ctrl1_reg[14:0]};
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= 32'h0000_0000;
    end else if (!i_bus.rd) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      unique case (i_bus.addr)
        `URX_OFF_CTRL1: o_rdata <= c1_view;
        `URX_OFF_CTRL2: o_rdata <= ctrl2_reg;
        `URX_OFF_CTRL3: o_rdata <= ctrl3_reg;
        `URX_OFF_DIV: o_rdata <= {16'h0000, div_reg};
        `URX_OFF_STAT: o_rdata <= stat;
        `URX_OFF_HOLD: o_rdata <= {23'h000000, hold_reg};
        default: o_rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : urx_rx

`default_nettype wire

// file: test/urx_rx_assertions.sv
// port assertions of the serial receive path
`timescale 1ns/1ns
`default_nettype none
`include "urx_params.svh"

module urx_rx_assertions (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // register port
  input wire urx_pkg::urx_bus_req_t i_bus,
  input wire logic [31:0] o_rdata,
  // line, dma and interrupt
  input wire logic i_rx,
  input wire logic i_dma_ack,
  input wire logic o_rx_dma_req,
  input wire logic o_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  logic on_sh;
  logic on_d;
  logic ie1_sh;
  logic ie3_sh;
  logic ie_any;
  logic on_st;
  logic rd_s;
  logic rd_h;
  logic rd_x;
  logic wr_q;
  assign ie_any = ie1_sh | ie3_sh;
  assign on_st = on_sh == on_d;
  assign rd_s = i_bus.rd && i_bus.addr == `URX_OFF_STAT;
  assign rd_h = i_bus.rd && i_bus.addr == `URX_OFF_HOLD;
  assign rd_x = i_bus.rd && i_bus.addr > `URX_OFF_HOLD;
  assign wr_q = i_bus.wr;
  // shadow of enables written to the first control register
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      on_sh <= 1'b0;
      ie1_sh <= 1'b0;
    end else if (i_bus.wr && i_bus.addr == `URX_OFF_CTRL1) begin
      on_sh <= i_bus.wdata[0] & i_bus.wdata[2];
      ie1_sh <= i_bus.wdata[4] | i_bus.wdata[5] | i_bus.wdata[8];
    end
  end
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ie3_sh <= 1'b0;
    end else if (i_bus.wr && i_bus.addr == `URX_OFF_CTRL3) begin
      ie3_sh <= i_bus.wdata[0];
    end
  end
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      on_d <= 1'b0;
    end else begin
      on_d <= on_sh;
    end
  end

  chk_rdata_idle: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
    else $error("read data outside answer cycle");
  chk_unmapped_zero: assert property ($past(rd_x) |-> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_hold_width: assert property ($past(rd_h) |-> o_rdata[31:9] == 23'h0)
    else $error("holding register too wide");
  chk_stat_spare: assert property ($past(rd_s) |-> o_rdata[21:6] == 16'h0)
    else $error("status spare bits set");
  chk_ack_follows: assert property (
    $past(rd_s) && $past(on_st) |-> o_rdata[22] == $past(on_sh))
    else $error("ready flag wrong");
  chk_irq_masked: assert property (!$past(ie_any) |-> !o_irq)
    else $error("interrupt with all enables off");
  chk_ack_drops: assert property (o_rx_dma_req && i_dma_ack |=> !o_rx_dma_req)
    else $error("dma request kept after ack");
  chk_req_holds: assert property (
    o_rx_dma_req && !i_dma_ack && !wr_q && !$past(wr_q) |=> o_rx_dma_req)
    else $error("dma request dropped");
  chk_reset_quiet: assert property (
    $fell(i_sys_rst) |-> (!o_irq && !o_rx_dma_req) ##1 (o_rdata == 32'h0))
    else $error("outputs active after reset");

  cover property ($rose(o_rx_dma_req));
  cover property ($rose(o_irq));
  cover property ($past(rd_h) && o_rdata[8:0] != 9'h0);
endmodule : urx_rx_assertions

bind urx_rx urx_rx_assertions i_urx_rx_assertions (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_rx(i_rx), .i_dma_ack(i_dma_ack), .o_rx_dma_req(o_rx_dma_req), .o_irq(o_irq)
);
`default_nettype wire

// file: test/urx_line_model.sv
// remote serial transmitter model driving the receive line
`timescale 1ns/1ns
`default_nettype none

module urx_line_model (
  // clock
  input wire logic i_core_clk,
  // serial line
  output var logic o_rx
);
  logic lvl;
  initial o_rx = 1'b1;
  task automatic hold(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : hold
  // frame of start bit and nb data bits, stop level sl for sc clocks, one-clock glitch at tick gt of bit gb
  task automatic send(input logic [8:0] d, input int nb, tb, sc, input logic sl, input int gb, gt);
    for (int i = 0; i <= nb; i++) begin
      lvl = (i == 0) ? 1'b0 : d[i-1];
      o_rx <= lvl;
      if (gt != 0 && gb == i) begin
        hold(gt - 1);
        o_rx <= ~lvl;
        hold(1);
        o_rx <= lvl;
        hold(tb - gt);
      end else begin
        hold(tb);
      end
    end
    o_rx <= sl;
    hold(sc);
    o_rx <= 1'b1;
    hold(1);
  endtask : send
  task automatic pulse(input int n);
    o_rx <= 1'b0;
    hold(n);
    o_rx <= 1'b1;
    hold(40);
  endtask : pulse
endmodule : urx_line_model
`default_nettype wire

// file: test/urx_rx_bench.sv
// self-checking bench of the serial receive path
`timescale 1ns/1ns
`default_nettype none
`include "urx_params.svh"

module urx_rx_bench;
  typedef struct packed {
    logic [8:0] d;
    logic [2:0] cfg;
    logic [1:0] stp;
    logic sl;
    logic [3:0] gb;
    logic [4:0] gt;
    logic [5:0] st;
  } urx_row_t;
  localparam urx_row_t rows [15] = '{
    '{9'h0a5, 3'b000, 2'b00, 1'b1, 4'h0, 5'h00, 6'h20},
    '{9'h1c3, 3'b110, 2'b00, 1'b1, 4'h0, 5'h00, 6'h20},
    '{9'h03c, 3'b000, 2'b00, 1'b0, 4'h0, 5'h00, 6'h22},
    '{9'h000, 3'b010, 2'b00, 1'b0, 4'h0, 5'h00, 6'h22},
    '{9'h000, 3'b000, 2'b01, 1'b0, 4'h0, 5'h00, 6'h20},
    '{9'h05a, 3'b000, 2'b10, 1'b0, 4'h0, 5'h00, 6'h22},
    '{9'h05a, 3'b001, 2'b11, 1'b0, 4'h0, 5'h00, 6'h22},
    '{9'h133, 3'b100, 2'b10, 1'b1, 4'h0, 5'h00, 6'h20},
    '{9'h0f0, 3'b000, 2'b11, 1'b1, 4'h0, 5'h00, 6'h20},
    '{9'h081, 3'b000, 2'b00, 1'b1, 4'h1, 5'h08, 6'h24},
    '{9'h081, 3'b001, 2'b00, 1'b1, 4'h1, 5'h08, 6'h20},
    '{9'h155, 3'b110, 2'b00, 1'b1, 4'h1, 5'h04, 6'h24},
    '{9'h066, 3'b000, 2'b00, 1'b1, 4'h0, 5'h05, 6'h24},
    '{9'h066, 3'b010, 2'b00, 1'b1, 4'h0, 5'h05, 6'h24},
    '{9'h066, 3'b001, 2'b00, 1'b1, 4'h0, 5'h05, 6'h20}
  };
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  urx_pkg::urx_bus_req_t i_bus = '0;
  logic i_dma_ack = 1'b0;
  wire logic [31:0] o_rdata;
  wire logic i_rx;
  wire logic o_rx_dma_req;
  wire logic o_irq;
  logic [31:0] rd_q;
  urx_row_t r;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int tb;
  int sc;

  urx_rx i_urx_rx (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_rx(i_rx), .i_dma_ack(i_dma_ack), .o_rx_dma_req(o_rx_dma_req), .o_irq(o_irq)
  );
  urx_line_model i_urx_line_model (.i_core_clk(i_core_clk), .o_rx(i_rx));

  initial forever #5 i_core_clk = ~i_core_clk;

  task automatic summarize();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_core_clk);
    i_bus <= '0;
    @(posedge i_core_clk);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
    i_bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge i_core_clk);
    i_bus <= '0;
    #1 rd_q = o_rdata;
    @(posedge i_core_clk);
    chk(rd_q & m, e);
  endtask : rc
  task automatic setup(input logic [2:0] c, input logic [1:0] s, input logic [31:0] c3);
    wr(`URX_OFF_CTRL2, {18'h0, s, 12'h0});
    wr(`URX_OFF_CTRL3, c3 | {20'h0, c[0], 11'h0});
    wr(`URX_OFF_CTRL1, {16'h0, c[1], 2'b00, c[2], 12'h005});
    wr(`URX_OFF_ICLR, 32'h1f);
  endtask : setup
  task automatic tx(input logic [8:0] d, input logic sl);
    i_urx_line_model.send(d, 8, 16, 16, sl, 0, 0);
  endtask : tx
  task automatic wait_full();
    for (int i = 0; i < 40; i++) begin
      rc(`URX_OFF_STAT, 32'h400000, 32'h400000);
      if (rd_q[5] === 1'b1) break;
    end
  endtask : wait_full

  initial begin
    repeat (5) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_core_clk);
    rc(`URX_OFF_DIV, 32'hffffffff, 32'h10);
    rc(`URX_OFF_STAT, 32'hffffffff, 32'h0);
    rc(8'h30, 32'hffffffff, 32'h0);
    wr(`URX_OFF_CTRL2, 32'h4000);
    wr(`URX_OFF_CTRL1, 32'h8005);
    rc(`URX_OFF_CTRL1, 32'h8000, 32'h0);
    foreach (rows[k]) begin
      r = rows[k];
      setup(r.cfg, r.stp, 32'h0);
      rc(`URX_OFF_STAT, 32'h400000, 32'h400000);
      tb = r.cfg[1] ? 8 : 16;
      sc = tb * (r.stp == 2'b01 ? 1 : r.stp == 2'b10 ? 4 : r.stp == 2'b11 ? 3 : 2) / 2;
      i_urx_line_model.send(r.d, 8 + r.cfg[2], tb, sc, r.sl, r.gb, r.gt);
      wait_full();
      rc(`URX_OFF_STAT, 32'h3f, {26'h0, r.st});
      rc(`URX_OFF_HOLD, 32'hffffffff, {23'h0, r.d});
      rc(`URX_OFF_STAT, 32'h20, 32'h0);
    end
    setup(3'b000, 2'b00, 32'h0);
    i_urx_line_model.pulse(2);
    i_urx_line_model.pulse(7);
    rc(`URX_OFF_STAT, 32'h3f, 32'h0);
    tx(9'h011, 1'b1);
    tx(9'h022, 1'b1);
    rc(`URX_OFF_STAT, 32'h28, 32'h28);
    rc(`URX_OFF_HOLD, 32'h1ff, 32'h011);
    wr(`URX_OFF_ICLR, 32'h8);
    rc(`URX_OFF_STAT, 32'h8, 32'h0);
    setup(3'b000, 2'b00, 32'h1000);
    tx(9'h033, 1'b1);
    tx(9'h044, 1'b1);
    rc(`URX_OFF_STAT, 32'h28, 32'h20);
    rc(`URX_OFF_HOLD, 32'h1ff, 32'h044);
    tx(9'h055, 1'b1);
    wr(`URX_OFF_REQ, 32'h8);
    rc(`URX_OFF_STAT, 32'h20, 32'h0);
    setup(3'b000, 2'b00, 32'h40);
    tx(9'h077, 1'b1);
    for (int i = 0; i < 40 && o_rx_dma_req !== 1'b1; i++) @(posedge i_core_clk);
    chk({31'h0, o_rx_dma_req}, 32'h1);
    rc(`URX_OFF_STAT, 32'h20, 32'h20);
    i_dma_ack <= 1'b1;
    @(posedge i_core_clk);
    i_dma_ack <= 1'b0;
    @(posedge i_core_clk);
    chk({31'h0, o_rx_dma_req}, 32'h0);
    rc(`URX_OFF_STAT, 32'h20, 32'h0);
    tx(9'h078, 1'b1);
    tx(9'h079, 1'b1);
    rc(`URX_OFF_STAT, 32'h8, 32'h8);
    wr(`URX_OFF_CTRL3, 32'h0);
    wr(`URX_OFF_CTRL1, 32'h15);
    rc(`URX_OFF_HOLD, 32'h1ff, 32'h078);
    wr(`URX_OFF_ICLR, 32'h1f);
    tx(9'h0ab, 1'b1);
    chk({31'h0, o_irq}, 32'h0);
    for (int i = 0; i < 300 && o_irq !== 1'b1; i++) @(posedge i_core_clk);
    chk({31'h0, o_irq}, 32'h1);
    rc(`URX_OFF_STAT, 32'h10, 32'h10);
    wr(`URX_OFF_ICLR, 32'h1f);
    @(posedge i_core_clk);
    chk({31'h0, o_irq}, 32'h0);
    wr(`URX_OFF_CTRL3, 32'h1);
    rc(`URX_OFF_HOLD, 32'h1ff, 32'h0ab);
    tx(9'h0ab, 1'b0);
    chk({31'h0, o_irq}, 32'h1);
    wr(`URX_OFF_ICLR, 32'h2);
    rc(`URX_OFF_STAT, 32'h2, 32'h0);
    wr(`URX_OFF_CTRL1, 32'h505);
    rc(`URX_OFF_HOLD, 32'h1ff, 32'h0ab);
    tx(9'h001, 1'b1);
    chk({31'h0, o_irq}, 32'h1);
    rc(`URX_OFF_STAT, 32'h21, 32'h21);
    wr(`URX_OFF_ICLR, 32'h1);
    rc(`URX_OFF_STAT, 32'h1, 32'h0);
    summarize();
  end
endmodule : urx_rx_bench
`default_nettype wire
